//--- verilog/pcq_pkg.sv
// What this block does
// - Up to eight independent queues exist, and software sets how many are active.
// - Each queue has a size register giving the most entries it may hold at once.
// - The full flag is high while the entry count is at or above the full level and low below it.
// - The full flag is status only and never blocks a write or raises an error.
// - The compare threshold is the oldest entry plus a signed offset.
// - Each queue selects feedback, master or commanded position as the compared quantity.
// - The exit event is high while the selected position is at or above the threshold.
// - The empty flag is high while no entry is stored and drops on the first write.
// - The overflow flag sets when a write arrives while the count is at or above the size.
// - A clear discards every stored entry and leaves the queue empty.
// - With compare enable low the comparator is off and the exit event stays low.
package pcq_pkg;
	localparam int NUM_Q = 8;
	localparam int DATA_W = 32;
	localparam int DEPTH = 16;
	localparam int PTR_W = 4;
	localparam int CNT_W = 5;
	localparam int ADDR_W = 9;
	localparam int QIDX_W = 3;

	// Global registers
	localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 9'h000;
	localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 9'h004;
	localparam logic [ADDR_W-1:0] ACTIVE_OFS = 9'h008;
	// Per-queue window: block index in addr[8:5], register in addr[4:0]
	localparam logic [3:0] QBLK_FIRST = 4'h2;
	localparam logic [4:0] Q_DATA_OFS = 5'h00;
	localparam logic [4:0] Q_CFG_OFS = 5'h04;
	localparam logic [4:0] Q_OFFSET_OFS = 5'h08;
	localparam logic [4:0] Q_CTRL_OFS = 5'h0c;
	localparam logic [4:0] Q_STATUS_OFS = 5'h10;

	// Config register fields
	localparam int CFG_SIZE_LSB = 0;
	localparam int CFG_FULL_LSB = 8;
	localparam int CFG_SRC_LSB = 16;
	localparam int CFG_CMPEN_BIT = 24;
	// Control register fields
	localparam int CTRL_CLEAR_BIT = 0;
	localparam int CTRL_POP_BIT = 1;
	// Status register fields
	localparam int ST_EMPTY_BIT = 8;
	localparam int ST_FULL_BIT = 9;
	localparam int ST_OVF_BIT = 10;
	localparam int ST_EXIT_BIT = 11;
	// Interrupt status: exit events low byte, overflow events next byte
	localparam int IRQ_OVF_LSB = 8;

	localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
	localparam logic [CNT_W-1:0] SIZE_RST = 5'h10;
	localparam logic [QIDX_W:0] ACTIVE_RST = 4'h8;

	typedef enum logic [1:0] {
		SRC_FEEDBACK,
		SRC_MASTER,
		SRC_COMMAND
	} src_e;

	typedef struct packed {
		logic signed [DATA_W-1:0] feedback;
		logic signed [DATA_W-1:0] master;
		logic signed [DATA_W-1:0] command;
	} pos_s;

	typedef struct packed {
		logic [CNT_W-1:0] size;
		logic [CNT_W-1:0] full_level;
		src_e src;
		logic cmp_en;
	} qcfg_s;

	typedef struct packed {
		logic [NUM_Q-1:0] empty;
		logic [NUM_Q-1:0] full;
		logic [NUM_Q-1:0] overflow;
		logic [NUM_Q-1:0] exit;
	} qflags_s;

	localparam qcfg_s CFG_RST = '{size: SIZE_RST, full_level: SIZE_RST, src: SRC_FEEDBACK, cmp_en: 1'b0};
endpackage

//--- verilog/position_compare_queue.sv
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module position_compare_queue (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [pcq_pkg::ADDR_W-1:0] addr_i,
	input wire logic [pcq_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [pcq_pkg::DATA_W-1:0] rdata_o,
	input wire pcq_pkg::pos_s pos_i,
	output pcq_pkg::qflags_s flags_o,
	output logic irq_o
);
	import pcq_pkg::*;

	logic signed [DATA_W-1:0] mem [NUM_Q][DEPTH];
	logic [PTR_W-1:0] rd_ptr_reg [NUM_Q];
	logic [PTR_W-1:0] rd_ptr_next [NUM_Q];
	logic [CNT_W-1:0] count_reg [NUM_Q];
	logic [CNT_W-1:0] count_next [NUM_Q];
	qcfg_s cfg_reg [NUM_Q];
	qcfg_s cfg_next [NUM_Q];
	logic signed [DATA_W-1:0] offset_reg [NUM_Q];
	logic signed [DATA_W-1:0] offset_next [NUM_Q];
	qflags_s flags_reg;
	qflags_s flags_next;
	logic [QIDX_W:0] active_reg;
	logic [QIDX_W:0] active_next;
	logic [2*NUM_Q-1:0] irq_stat_reg;
	logic [2*NUM_Q-1:0] irq_stat_next;
	logic [2*NUM_Q-1:0] irq_mask_reg;
	logic [2*NUM_Q-1:0] irq_mask_next;
	logic irq_reg;
	logic irq_next;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic mem_we;
	logic [QIDX_W-1:0] mem_wq;
	logic [PTR_W-1:0] mem_wa;
	logic signed [DATA_W-1:0] mem_wd;
	logic [CNT_W-1:0] act_sat;
	logic [NUM_Q-1:0] exit_cmp;
	logic [NUM_Q-1:0] push_ev;
	logic [NUM_Q-1:0] pop_ev;
	logic [NUM_Q-1:0] clr_ev;

	// Saturate a written count field into lo..DEPTH
	function automatic logic [CNT_W-1:0] sat_cnt(input logic [7:0] v, input logic [CNT_W-1:0] lo);
		logic [CNT_W-1:0] r;
		r = (v > 8'(DEPTH)) ? CNT_W'(DEPTH) : v[CNT_W-1:0];
		if (r < lo) begin
			r = lo;
		end
		return r;
	endfunction

	// Threshold one bit wider so data plus offset cannot wrap
	function automatic logic signed [DATA_W:0] threshold(input logic signed [DATA_W-1:0] d,
		input logic signed [DATA_W-1:0] o);
		return $signed({d[DATA_W-1], d}) + $signed({o[DATA_W-1], o});
	endfunction

	function automatic logic signed [DATA_W-1:0] pick_pos(input pos_s p, input src_e s);
		logic signed [DATA_W-1:0] r;
		unique case (s)
			SRC_MASTER: r = p.master;
			SRC_COMMAND: r = p.command;
			default: r = p.feedback;
		endcase
		return r;
	endfunction

	// Queue block select; out-of-range blocks decode as not hit
	function automatic logic q_hit(input logic [ADDR_W-1:0] a, input int q, input logic [QIDX_W:0] act);
		logic [3:0] blk;
		blk = a[ADDR_W-1:5] - QBLK_FIRST;
		return (a[ADDR_W-1:5] >= QBLK_FIRST) && (blk == 4'(q)) && (4'(q) < act);
	endfunction

	// Comparator per queue, on the oldest entry
	always_comb begin
		for (int q = 0; q < NUM_Q; q++) begin
			exit_cmp[q] = cfg_reg[q].cmp_en && (count_reg[q] != '0) &&
				((DATA_W+1)'(pick_pos(pos_i, cfg_reg[q].src)) >=
				threshold(mem[q][rd_ptr_reg[q]], offset_reg[q]));
		end
	end

	always_comb begin
		// Saturate in count width first; a plain slice would turn 16 into 0
		act_sat = sat_cnt(wdata_i[7:0], CNT_ONE);
		active_next = active_reg;
		irq_mask_next = irq_mask_reg;
		mem_we = 1'b0;
		mem_wq = '0;
		mem_wa = '0;
		mem_wd = wdata_i;
		flags_next = flags_reg;
		push_ev = '0;
		pop_ev = '0;
		clr_ev = '0;
		if (wr_i && addr_i == ACTIVE_OFS) begin
			active_next = (act_sat > CNT_W'(ACTIVE_RST)) ? ACTIVE_RST : act_sat[QIDX_W:0];
		end
		if (wr_i && addr_i == IRQ_MASK_OFS) begin
			irq_mask_next = wdata_i[2*NUM_Q-1:0];
		end
		for (int q = 0; q < NUM_Q; q++) begin
			rd_ptr_next[q] = rd_ptr_reg[q];
			count_next[q] = count_reg[q];
			cfg_next[q] = cfg_reg[q];
			offset_next[q] = offset_reg[q];
			if (wr_i && q_hit(addr_i, q, active_reg)) begin
				unique case (addr_i[4:0])
					Q_DATA_OFS: push_ev[q] = 1'b1;
					Q_CFG_OFS: begin
						cfg_next[q].size = sat_cnt(8'(wdata_i[CFG_SIZE_LSB +: CNT_W]), CNT_ONE);
						cfg_next[q].full_level = sat_cnt(8'(wdata_i[CFG_FULL_LSB +: CNT_W]), '0);
						cfg_next[q].src = src_e'(wdata_i[CFG_SRC_LSB +: 2]);
						cfg_next[q].cmp_en = wdata_i[CFG_CMPEN_BIT];
					end
					Q_OFFSET_OFS: offset_next[q] = wdata_i;
					Q_CTRL_OFS: begin
						clr_ev[q] = wdata_i[CTRL_CLEAR_BIT];
						pop_ev[q] = wdata_i[CTRL_POP_BIT];
					end
					default: ;
				endcase
			end
			// Shrinking the active count also drops the queues beyond it
			if (4'(q) >= active_reg) begin
				clr_ev[q] = 1'b1;
			end
			if (clr_ev[q]) begin
				count_next[q] = '0;
				rd_ptr_next[q] = '0;
				flags_next.overflow[q] = 1'b0;
			end else if (push_ev[q]) begin
				if (count_reg[q] >= cfg_reg[q].size) begin
					flags_next.overflow[q] = 1'b1;
				end else begin
					// Full flag does not gate this path
					mem_we = 1'b1;
					mem_wq = QIDX_W'(q);
					mem_wa = rd_ptr_reg[q] + count_reg[q][PTR_W-1:0];
					count_next[q] = count_reg[q] + CNT_ONE;
				end
			end else if (pop_ev[q] && count_reg[q] != '0) begin
				rd_ptr_next[q] = rd_ptr_reg[q] + PTR_W'(1);
				count_next[q] = count_reg[q] - CNT_ONE;
			end
			flags_next.empty[q] = (count_next[q] == '0);
			flags_next.full[q] = (count_next[q] >= cfg_next[q].full_level);
			flags_next.exit[q] = exit_cmp[q] && !clr_ev[q];
		end
	end

	// Sticky event bits: a new event wins over a same-cycle clear
	always_comb begin
		irq_stat_next = irq_stat_reg;
		if (wr_i && addr_i == IRQ_STAT_OFS) begin
			irq_stat_next = irq_stat_reg & ~wdata_i[2*NUM_Q-1:0];
		end
		irq_stat_next[NUM_Q-1:0] = irq_stat_next[NUM_Q-1:0] | (flags_next.exit & ~flags_reg.exit);
		irq_stat_next[IRQ_OVF_LSB +: NUM_Q] = irq_stat_next[IRQ_OVF_LSB +: NUM_Q]
			| (flags_next.overflow & ~flags_reg.overflow);
		irq_next = |(irq_stat_next & irq_mask_next);
	end

	always_comb begin
		rdata_next = '0;
		if (rd_i) begin
			unique case (addr_i)
				IRQ_STAT_OFS: rdata_next = DATA_W'(irq_stat_reg);
				IRQ_MASK_OFS: rdata_next = DATA_W'(irq_mask_reg);
				ACTIVE_OFS: rdata_next = DATA_W'(active_reg);
				default: begin
					for (int q = 0; q < NUM_Q; q++) begin
						if (q_hit(addr_i, q, active_reg)) begin
							unique case (addr_i[4:0])
								Q_DATA_OFS: rdata_next = (count_reg[q] != '0) ? mem[q][rd_ptr_reg[q]] : '0;
								Q_CFG_OFS: begin
									rdata_next[CFG_SIZE_LSB +: CNT_W] = cfg_reg[q].size;
									rdata_next[CFG_FULL_LSB +: CNT_W] = cfg_reg[q].full_level;
									rdata_next[CFG_SRC_LSB +: 2] = cfg_reg[q].src;
									rdata_next[CFG_CMPEN_BIT] = cfg_reg[q].cmp_en;
								end
								Q_OFFSET_OFS: rdata_next = offset_reg[q];
								Q_STATUS_OFS: begin
									rdata_next[CNT_W-1:0] = count_reg[q];
									rdata_next[ST_EMPTY_BIT] = flags_reg.empty[q];
									rdata_next[ST_FULL_BIT] = flags_reg.full[q];
									rdata_next[ST_OVF_BIT] = flags_reg.overflow[q];
									rdata_next[ST_EXIT_BIT] = flags_reg.exit[q];
								end
								default: ;
							endcase
						end
					end
				end
			endcase
		end
	end

	// Storage has no reset: a clear only moves pointers, stale words are unreachable
	always_ff @(posedge clk_i) begin
		if (mem_we) begin
			mem[mem_wq][mem_wa] <= mem_wd;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int q = 0; q < NUM_Q; q++) begin
				rd_ptr_reg[q] <= '0;
				count_reg[q] <= '0;
				cfg_reg[q] <= CFG_RST;
				offset_reg[q] <= '0;
			end
			flags_reg <= '{empty: '1, full: '0, overflow: '0, exit: '0};
			active_reg <= ACTIVE_RST;
			irq_stat_reg <= '0;
			irq_mask_reg <= '0;
			irq_reg <= 1'b0;
			rdata_reg <= '0;
		end else begin
			rd_ptr_reg <= rd_ptr_next;
			count_reg <= count_next;
			cfg_reg <= cfg_next;
			offset_reg <= offset_next;
			flags_reg <= flags_next;
			active_reg <= active_next;
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
			irq_reg <= irq_next;
			rdata_reg <= rdata_next;
		end
	end

	assign rdata_o = rdata_reg;
	assign flags_o = flags_reg;
	assign irq_o = irq_reg;

	// Checks on queue 0, and on queue NUM_Q-1 for the inactive clear; the other queues share the same loop body
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	logic push0;
	logic pop0;
	logic clr0;
	assign push0 = push_ev[0] && !clr_ev[0];
	assign pop0 = pop_ev[0] && !clr_ev[0] && !push_ev[0];
	assign clr0 = clr_ev[0];

	a_push_not_blocked: assert property (push0 && count_reg[0] < cfg_reg[0].size && flags_reg.full[0]
		|=> count_reg[0] == $past(count_reg[0]) + CNT_ONE) else $error("write blocked by full flag");
	a_overflow_sets: assert property (push0 && count_reg[0] == cfg_reg[0].size
		|=> flags_o.overflow[0] && irq_stat_reg[IRQ_OVF_LSB] == ($past(irq_stat_reg[IRQ_OVF_LSB])
		|| !$past(flags_o.overflow[0]))) else $error("overflow not flagged");
	a_overflow_discard: assert property (push0 && count_reg[0] == cfg_reg[0].size
		|=> $stable(count_reg[0]) && $stable(rd_ptr_reg[0])) else $error("overflow write stored");
	a_clear_empties: assert property (clr0 |=> count_reg[0] == '0 && flags_o.empty[0]
		&& !flags_o.overflow[0]) else $error("clear left entries");
	a_exit_disabled: assert property (!cfg_reg[0].cmp_en |=> !flags_o.exit[0]) else $error("exit while disabled");
	a_full_level: assert property (flags_o.full[0] == (count_reg[0] >= cfg_reg[0].full_level))
		else $error("full flag mismatch");
	a_empty_flag: assert property (push0 && count_reg[0] == '0 && cfg_reg[0].size != '0
		|=> !flags_o.empty[0]) else $error("empty flag stuck");
	a_exit_cause: assert property (flags_o.exit[0] |-> $past(cfg_reg[0].cmp_en) && $past(count_reg[0] != '0)
		&& $past((DATA_W+1)'(pick_pos(pos_i, cfg_reg[0].src)) >= threshold(mem[0][rd_ptr_reg[0]], offset_reg[0])))
		else $error("exit without cause");
	a_fifo_order: assert property (pop0 && count_reg[0] > CNT_ONE
		|=> mem[0][rd_ptr_reg[0]] == $past(mem[0][rd_ptr_reg[0] + PTR_W'(1)])) else $error("pop order wrong");
	a_active_limit: assert property (active_reg <= ACTIVE_RST && active_reg != '0)
		else $error("active count out of range");
	a_read_latency: assert property (rd_i && addr_i == ACTIVE_OFS |=> rdata_o == DATA_W'($past(active_reg)))
		else $error("read data late");
	a_read_idle: assert property (!rd_i |=> rdata_o == '0) else $error("read data outside read slot");
	a_irq_level: assert property (irq_o == |(irq_stat_reg & irq_mask_reg)) else $error("irq level mismatch");
	a_pop_empty: assert property (pop0 && count_reg[0] == '0
		|=> count_reg[0] == '0 && $stable(rd_ptr_reg[0]) && flags_o.empty[0]) else $error("pop on empty moved queue");
	a_inactive_clear: assert property (active_reg < ACTIVE_RST |=> flags_o.empty[NUM_Q-1])
		else $error("inactive queue holds entries");

	c_overflow: cover property (push0 && count_reg[0] == cfg_reg[0].size);
	c_exit_fire: cover property (!flags_o.exit[0] ##1 flags_o.exit[0] ##1 pop0);
	c_full_then_empty: cover property (flags_o.full[0] ##[1:40] flags_o.empty[0]);
	c_irq: cover property (irq_o);
endmodule

//--- verification/motion_program.sv
`timescale 1ns/100ps
module motion_program (
	input wire logic clk_i,
	input wire logic [pcq_pkg::DATA_W-1:0] rdata_i,
	output logic [pcq_pkg::ADDR_W-1:0] addr_o,
	output logic [pcq_pkg::DATA_W-1:0] wdata_o,
	output logic wr_o,
	output logic rd_o,
	output pcq_pkg::pos_s pos_o
);
	import pcq_pkg::*;

	initial begin
		addr_o = '0;
		wdata_o = '0;
		wr_o = 1'b0;
		rd_o = 1'b0;
		pos_o = '0;
	end

	function automatic logic [ADDR_W-1:0] qa(input int q, input logic [4:0] o);
		return {4'(QBLK_FIRST + 4'(q)), o};
	endfunction

	// Entries only ever arrive through these explicit writes
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
		#1;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		#1;
		d = rdata_i;
	endtask

	task automatic set_pos(input pos_s p);
		@(posedge clk_i);
		pos_o <= p;
	endtask

	// Storage is not reset, so stale entries are flushed first
	task automatic clear_all();
		for (int q = 0; q < NUM_Q; q++) begin
			wr(qa(q, Q_CTRL_OFS), 32'h0000_0001);
		end
	endtask
endmodule

//--- verification/testbench.sv
`timescale 1ns/100ps
module testbench;
	import pcq_pkg::*;
	logic clk_i;
	logic rst_i;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic wr;
	logic rd;
	pos_s pos;
	qflags_s flags;
	logic irq;
	int n_fail = 0;
	int compares = 0;

	position_compare_queue position_compare_queue_i (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.addr_i(addr),
		.wdata_i(wdata),
		.wr_i(wr),
		.rd_i(rd),
		.rdata_o(rdata),
		.pos_i(pos),
		.flags_o(flags),
		.irq_o(irq)
	);

	motion_program prog_i (
		.clk_i(clk_i),
		.rdata_i(rdata),
		.addr_o(addr),
		.wdata_o(wdata),
		.wr_o(wr),
		.rd_o(rd),
		.pos_o(pos)
	);

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		logic [DATA_W-1:0] d;
		prog_i.rd(a, d);
		check(d, exp);
	endtask

	task automatic push(input int q, input logic [31:0] v);
		prog_i.wr(prog_i.qa(q, Q_DATA_OFS), v);
	endtask

	task automatic t_reset();
		check(32'(flags.empty), 32'h0000_00ff);
		check(32'(flags.full | flags.overflow | flags.exit), 32'h0);
		prog_i.clear_all();
	endtask

	// Size 3, full level 2: full reached before the queue is full
	task automatic t_fill();
		prog_i.wr(prog_i.qa(0, Q_CFG_OFS), 32'h0000_0203);
		rdchk(prog_i.qa(0, Q_CFG_OFS), 32'h0000_0203);
		push(0, 32'h11);
		check(32'(flags.empty[0]), 32'h0);
		check(32'(flags.full[0]), 32'h0);
		push(0, 32'h22);
		check(32'(flags.full[0]), 32'h1);
		push(0, 32'h33);
		rdchk(prog_i.qa(0, Q_STATUS_OFS), 32'h0000_0203);
		push(0, 32'h44);
		check(32'(flags.overflow[0]), 32'h1);
		rdchk(prog_i.qa(0, Q_STATUS_OFS), 32'h0000_0603);
		rdchk(prog_i.qa(0, Q_DATA_OFS), 32'h11);
		prog_i.wr(prog_i.qa(0, Q_CTRL_OFS), 32'h0000_0002);
		rdchk(prog_i.qa(0, Q_DATA_OFS), 32'h22);
		prog_i.wr(prog_i.qa(0, Q_CTRL_OFS), 32'h0000_0002);
		check(32'(flags.full[0]), 32'h0);
		rdchk(prog_i.qa(0, Q_DATA_OFS), 32'h33);
		prog_i.wr(prog_i.qa(0, Q_CTRL_OFS), 32'h0000_0001);
		check(32'(flags.empty[0]), 32'h1);
		rdchk(prog_i.qa(0, Q_STATUS_OFS), 32'h0000_0100);
		prog_i.wr(prog_i.qa(0, Q_CTRL_OFS), 32'h0000_0002);
		rdchk(prog_i.qa(0, Q_STATUS_OFS), 32'h0000_0100);
	endtask

	// Unselected positions sit far past the threshold to expose a wrong source
	task automatic exit_at(input int s, input logic [31:0] v, input logic e);
		pos_s p;
		p = '{feedback: 32'd100, master: 32'd100, command: 32'd100};
		if (s == 0) p.feedback = v;
		if (s == 1) p.master = v;
		if (s == 2) p.command = v;
		prog_i.set_pos(p);
		repeat (2) @(posedge clk_i);
		#1;
		check(32'(flags.exit[1]), 32'(e));
	endtask

	task automatic t_compare();
		prog_i.wr(prog_i.qa(1, Q_OFFSET_OFS), 32'd10);
		push(1, 32'd5);
		for (int s = 0; s < 3; s++) begin
			prog_i.wr(prog_i.qa(1, Q_CFG_OFS), 32'h0000_1010 | (s << CFG_SRC_LSB));
			exit_at(s, 32'd100, 1'b0);
			prog_i.wr(prog_i.qa(1, Q_CFG_OFS), 32'h0100_1010 | (s << CFG_SRC_LSB));
			exit_at(s, 32'd14, 1'b0);
			exit_at(s, 32'd15, 1'b1);
			exit_at(s, 32'hffff_fff0, 1'b0);
			exit_at(s, 32'd15, 1'b1);
		end
	endtask

	task automatic t_irq();
		check(32'(irq), 32'h0);
		prog_i.wr(IRQ_MASK_OFS, 32'h0000_0002);
		@(posedge clk_i);
		#1;
		check(32'(irq), 32'h1);
		prog_i.wr(IRQ_STAT_OFS, 32'h0000_ffff);
		@(posedge clk_i);
		#1;
		check(32'(irq), 32'h0);
		rdchk(IRQ_STAT_OFS, 32'h0);
		prog_i.wr(IRQ_MASK_OFS, 32'h0);
	endtask

	task automatic t_active();
		prog_i.wr(ACTIVE_OFS, 32'h2);
		push(3, 32'h5);
		check(32'(flags.empty[3]), 32'h1);
		rdchk(prog_i.qa(3, Q_STATUS_OFS), 32'h0);
		rdchk(ACTIVE_OFS, 32'h2);
		prog_i.wr(ACTIVE_OFS, 32'h0);
		rdchk(ACTIVE_OFS, 32'h1);
		prog_i.wr(ACTIVE_OFS, 32'h10);
		rdchk(ACTIVE_OFS, 32'h8);
		push(7, 32'h5);
		check(32'(flags.empty[7]), 32'h0);
		rdchk(9'h00c, 32'h0);
	endtask

	task automatic results();
		if (n_fail == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Whole sequence needs under 200 cycles; this leaves ample room
	initial begin
		#2000000;
		n_fail++;
		results();
	end

	initial begin
		rst_i = 1'b1;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_fill();
		t_compare();
		t_irq();
		t_active();
		results();
	end
endmodule
